/* obb_pkg.sv */
// Shared constants for the option bus buffer bridge
package obb_pkg;
  localparam logic [15:0] OPT_SPACE_LO     = 16'h1000;
  localparam logic [15:0] OPT_SPACE_HI     = 16'h7FFF;
  localparam logic [3:0]  ROM_PAGE_DIGIT   = 4'h1;
  localparam logic [11:0] PAGE_TOP_LO      = 12'hFFC;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          PHASE_DELAY_NS   = 30;
  // More than the delay: one whole cycle beyond the printed figure
  localparam int          PHASE_DELAY_CYC  = PHASE_DELAY_NS / CLK_PERIOD_NS + 1;
  localparam int          READ_DELAY_TICKS = 2;
  localparam int          WRITE_DELAY_TICKS = 1;
  localparam logic [1:0]  CTRL_CLEAR_VAL   = 2'h3;
endpackage

/* obb_delay_line.sv */
// Shift delay line with advance and synchronous clear
`timescale 1ns/1ns
`default_nettype none
module obb_delay_line #(
  parameter int         DEPTH   = 2,
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] CLR_VAL = '0
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             advance_i,
  input  wire logic             clear_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] first_o,
  output logic      [WIDTH-1:0] last_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } obb_dl_state_t;

  obb_dl_state_t s;
  obb_dl_state_t next_s;

  always_comb begin
    next_s = s;
    if (clear_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        next_s.stage[i] = CLR_VAL;
      end
    end else if (advance_i) begin
      next_s.stage[0] = data_i;
      for (int i = 1; i < DEPTH; i++) begin
        next_s.stage[i] = s.stage[i-1];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        s.stage[i] <= CLR_VAL;
      end
    end else begin
      s <= next_s;
    end
  end

  assign first_o = s.stage[0];
  assign last_o  = s.stage[DEPTH-1];
endmodule
`default_nettype wire

/* obb_bridge.sv */
// Option bus buffer bridge: decode, ROM enable, bus timing, data buffer steering
`timescale 1ns/1ns
`default_nettype none
module obb_bridge
  import obb_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              valid_memory_access_i,
  input  wire logic              rd_wr_i,
  input  wire logic              phase_n_i,
  input  wire logic              reset_n_in_i,
  input  wire logic              ten_meg_clock_i,
  input  wire logic              rom_space_jumper_i,
  input  wire logic              nvm_clock_i,
  input  wire logic              mode_one_i,
  input  wire logic              mode_three_i,
  output logic                   option_space_select_o,
  output logic                   local_rom_space_n_o,
  output logic                   page_top_strobe_n_o,
  output logic                   rom_output_enable_n_o,
  output logic                   buffered_ten_meg_clock_o,
  output logic                   delayed_phase_clock_o,
  output logic                   opt_valid_memory_access_o,
  output logic                   opt_rd_wr_o,
  output logic      [ADDR_W-1:0] opt_addr_o,
  output logic                   opt_reset_n_o,
  output logic                   opt_phase_n_o,
  output logic                   buf_dir_o,
  output logic                   buf_en_n_o,
  output logic                   nvm_clock_o,
  output logic                   memory_mode_input_one_o,
  output logic                   memory_mode_input_three_o
);
  typedef struct packed {
    logic              ten_q;
    logic              ten_prev;
    logic              rw_q;
    logic              opt_sel;
    logic              rom_n;
    logic              top_n;
    logic              rom_oe_n;
    logic              dir;
    logic              en_n;
    logic              valid_mem;
    logic              rw;
    logic [ADDR_W-1:0] addr;
    logic              reset_n;
    logic              phase_n;
    logic              dphase_prev;
    logic              nvm_clk;
    logic              mode1;
    logic              mode3;
  } obb_state_t;

  obb_state_t s;
  obb_state_t next_s;

  logic       tick;
  logic       read_opt;
  logic       dphase;
  logic [1:0] ctrl_first;
  logic [1:0] ctrl_last;

  assign tick     = s.ten_q & ~s.ten_prev;
  assign read_opt = s.opt_sel & s.rw_q;

  // Delayed phase clock, runs on every system edge
  obb_delay_line #(
    .DEPTH   (PHASE_DELAY_CYC),
    .WIDTH   (1),
    .CLR_VAL (1'b0)
  ) u_phase_delay (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .advance_i (1'b1),
    .clear_i   (1'b0),
    .data_i    (~s.phase_n),
    .first_o   (),
    .last_o    (dphase)
  );

  // Buffer control shifter: {direction, enable_n}, stepped by 10 MHz ticks
  obb_delay_line #(
    .DEPTH   (READ_DELAY_TICKS),
    .WIDTH   (2),
    .CLR_VAL (CTRL_CLEAR_VAL)
  ) u_ctrl_shift (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .advance_i (tick),
    .clear_i   (~s.rom_oe_n),
    .data_i    ({~read_opt, s.phase_n}),
    .first_o   (ctrl_first),
    .last_o    (ctrl_last)
  );

  always_comb begin
    next_s          = s;
    next_s.ten_q    = ten_meg_clock_i;
    next_s.ten_prev = s.ten_q;
    next_s.rw_q     = rd_wr_i;
    next_s.opt_sel  = (addr_i >= OPT_SPACE_LO) && (addr_i <= OPT_SPACE_HI);
    next_s.rom_n    = ~(addr_i[15:12] == ROM_PAGE_DIGIT);
    next_s.top_n    = ~(addr_i[11:0] >= PAGE_TOP_LO);
    // Without the jumper the ROM stays off rather than answering everywhere
    next_s.rom_oe_n = rom_space_jumper_i ? next_s.rom_n : 1'b1;
    // Direction follows the two-tick delayed read condition
    next_s.dir      = ctrl_last[1];
    // Reads wait two ticks, writes one; any direction skew or ROM access
    // keeps drivers off so the bus never sees two drivers
    next_s.en_n     = (ctrl_last[1] ? ctrl_first[0] : ctrl_last[0])
                      | (ctrl_last[1] != ctrl_first[1])
                      | (ctrl_last[1] != s.dir)
                      | ~s.rom_oe_n;
    next_s.reset_n  = reset_n_in_i;
    next_s.phase_n  = phase_n_i;
    next_s.dphase_prev = dphase;
    if (dphase && !s.dphase_prev) begin
      next_s.valid_mem = valid_memory_access_i;
      next_s.rw   = rd_wr_i;
      next_s.addr = addr_i;
    end
    // Host chooses one memory by its clock; we only forward it
    next_s.nvm_clk  = nvm_clock_i;
    next_s.mode1    = mode_three_i;
    next_s.mode3    = mode_one_i;
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s         <= '0;
      s.rom_n   <= 1'b1;
      s.top_n   <= 1'b1;
      s.rom_oe_n <= 1'b1;
      s.dir     <= 1'b1;
      s.en_n    <= 1'b1;
      s.phase_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign option_space_select_o     = s.opt_sel;
  assign local_rom_space_n_o       = s.rom_n;
  assign page_top_strobe_n_o       = s.top_n;
  assign rom_output_enable_n_o     = s.rom_oe_n;
  assign buffered_ten_meg_clock_o  = s.ten_q;
  assign delayed_phase_clock_o     = dphase;
  assign opt_valid_memory_access_o = s.valid_mem;
  assign opt_rd_wr_o               = s.rw;
  assign opt_addr_o                = s.addr;
  assign opt_reset_n_o             = s.reset_n;
  assign opt_phase_n_o             = s.phase_n;
  assign buf_dir_o                 = s.dir;
  assign buf_en_n_o                = s.en_n;
  assign nvm_clock_o               = s.nvm_clk;
  assign memory_mode_input_one_o   = s.mode1;
  assign memory_mode_input_three_o = s.mode3;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_opt_select: assert property (
    ##1 option_space_select_o == $past(addr_i >= OPT_SPACE_LO && addr_i <= OPT_SPACE_HI))
    else $error("option select wrong");
  a_rom_space: assert property (
    ##1 !local_rom_space_n_o == $past(addr_i[15:12] == ROM_PAGE_DIGIT))
    else $error("rom space select wrong");
  a_page_top: assert property (
    ##1 !page_top_strobe_n_o == $past(addr_i[11:0] >= PAGE_TOP_LO))
    else $error("page top strobe wrong");
  a_rom_jumper: assert property (
    ##1 $past(rom_space_jumper_i) |-> rom_output_enable_n_o == local_rom_space_n_o)
    else $error("rom enable differs from rom select");
  a_rom_clear: assert property (
    !rom_output_enable_n_o |=> buf_en_n_o)
    else $error("buffer enabled during rom access");
  a_clock_fwd: assert property (
    ##1 buffered_ten_meg_clock_o == $past(ten_meg_clock_i))
    else $error("ten meg clock not forwarded");
  a_pass_reset: assert property (
    ##1 $past(nrst_i) |->
      opt_reset_n_o == $past(reset_n_in_i) && opt_phase_n_o == $past(phase_n_i))
    else $error("reset or phase not passed");
  a_phase_delay: assert property (
    ##5 delayed_phase_clock_o == !$past(phase_n_i, 5))
    else $error("delayed phase clock wrong");
  a_one_driver: assert property (
    $changed(buf_dir_o) |-> buf_en_n_o && $past(buf_en_n_o))
    else $error("direction changed while driving");
  a_mode_swap: assert property (
    ##1 memory_mode_input_one_o == $past(mode_three_i) &&
        memory_mode_input_three_o == $past(mode_one_i))
    else $error("memory mode inputs not swapped");
  a_dir_read: assert property (
    $fell(buf_dir_o) |-> !ctrl_last[1])
    else $error("direction low outside option read");

  c_opt_read: cover property (!buf_dir_o && !buf_en_n_o);
  c_opt_write: cover property (buf_dir_o && !buf_en_n_o);
  c_rom_read: cover property (!rom_output_enable_n_o);
  c_page_top: cover property (!page_top_strobe_n_o && option_space_select_o);
endmodule
`default_nettype wire

/* obb_host_model.sv */
// Host board model: 10 MHz clock, phase clock and memory clock
`timescale 1ns/1ns
`default_nettype none
module obb_host_model (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic e_true_i,
  input  wire logic nvm_sel_i,
  output logic      ten_meg_clock_o,
  output logic      phase_n_o,
  output logic      nvm_clock_o
);
  logic [2:0] div;
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      div <= 3'h0;
      ten_meg_clock_o <= 1'b0;
      phase_n_o <= 1'b1;
      nvm_clock_o <= 1'b0;
    end else begin
      div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
      phase_n_o <= !e_true_i;
      if (div == 3'h4) begin
        ten_meg_clock_o <= !ten_meg_clock_o;
        // Board memory clock runs only while selected, idles low
        nvm_clock_o <= nvm_sel_i & !nvm_clock_o;
      end
    end
  end
endmodule
`default_nettype wire

/* obb_bridge_test.sv */
// Self-checking testbench for the option bus buffer bridge
`timescale 1ns/1ns
`default_nettype none
module obb_bridge_test;
  import obb_pkg::*;
  typedef struct {int k; logic [17:0] v;} obb_note_t;
  logic clock_i = 0, nrst = 0, vld = 1, rd_wr = 0, e_true = 0, jumper = 0, nvm_sel = 0;
  logic m1 = 0, m3 = 0, rst_in_n = 1, pd = 1, pe = 1, tmc, ph_n, nvmc;
  logic tmc_p = 0, ph_p = 1, nvmc_p = 0, btmc, oph, onvm;
  logic [15:0] addr = 16'h0000;
  logic osel, rom_n, str_n, rom_oe_n, dir, en_n, dph, ovld, orw, ores, m1o, m3o;
  logic [15:0] oaddr;
  int mismatches = 0, n_tests = 0, cyc = 0;
  obb_note_t q[$];
  event samp;
  initial forever #5 clock_i = !clock_i;
  obb_host_model host (.clock_i(clock_i), .nrst_i(nrst), .e_true_i(e_true),
    .nvm_sel_i(nvm_sel), .ten_meg_clock_o(tmc), .phase_n_o(ph_n), .nvm_clock_o(nvmc));
  obb_bridge uut (.clock_i(clock_i), .nrst_i(nrst), .addr_i(addr), .valid_memory_access_i(vld),
    .rd_wr_i(rd_wr), .phase_n_i(ph_n), .reset_n_in_i(rst_in_n), .ten_meg_clock_i(tmc),
    .rom_space_jumper_i(jumper), .nvm_clock_i(nvmc), .mode_one_i(m1), .mode_three_i(m3),
    .option_space_select_o(osel), .local_rom_space_n_o(rom_n), .page_top_strobe_n_o(str_n),
    .rom_output_enable_n_o(rom_oe_n), .buffered_ten_meg_clock_o(btmc),
    .delayed_phase_clock_o(dph), .opt_valid_memory_access_o(ovld), .opt_rd_wr_o(orw),
    .opt_addr_o(oaddr), .opt_reset_n_o(ores), .opt_phase_n_o(oph), .buf_dir_o(dir),
    .buf_en_n_o(en_n), .nvm_clock_o(onvm),
    .memory_mode_input_one_o(m1o), .memory_mode_input_three_o(m3o));
  task automatic finish_test;
    $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp_decode(input logic [6:0] e, input logic [6:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR decode expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_buffer(input logic [1:0] e, input logic [1:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR buffer_control expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_latch(input logic [17:0] e, input logic [17:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR option_latch expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_phase(input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR delayed_phase expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_hold(input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR direction_hold expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_drivers(input logic [1:0] e, input logic [1:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR drivers_off expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_forward(input logic [2:0] e, input logic [2:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR forwarded_lines expected %h seen %h", e, s);
    end
  endtask
  task automatic note(input int k, input logic [17:0] v, input int n);
    q.push_back('{k, v});
    repeat (n) @(posedge clock_i);
    #1;
    -> samp;
  endtask
  task automatic dec(input logic [15:0] a);
    logic j, x1, x3, rn, ns;
    j = 1'($urandom);
    x1 = 1'($urandom);
    x3 = 1'($urandom);
    rn = 1'($urandom);
    ns = 1'($urandom);
    @(posedge clock_i);
    addr <= a;
    jumper <= j;
    m1 <= x1;
    m3 <= x3;
    rst_in_n <= rn;
    nvm_sel <= ns;
    note(0, 18'({a >= OPT_SPACE_LO && a <= OPT_SPACE_HI, a[15:12] != ROM_PAGE_DIGIT,
      a[11:0] < PAGE_TOP_LO, j ? a[15:12] != ROM_PAGE_DIGIT : 1'b1,
      x3, x1, rn}), 2);
  endtask
  // Option traffic: direction must not move early, then settle
  task automatic bus(input logic [15:0] a, input logic r, j, e, input logic [1:0] x);
    logic d0;
    d0 = dir;
    @(posedge clock_i);
    addr <= a;
    rd_wr <= r;
    jumper <= j;
    e_true <= e;
    note(4, 18'(d0), 8);
    note(1, 18'(x), 40);
  endtask
  task automatic latch(input logic [15:0] a, input logic v, r);
    @(posedge clock_i);
    e_true <= 0;
    repeat (12) @(posedge clock_i);
    addr <= a;
    vld <= v;
    rd_wr <= r;
    e_true <= 1;
    note(3, 18'(0), 4);
    note(2, {v, r, a}, 6);
    @(posedge clock_i);
    addr <= ~a;
    vld <= !v;
    note(2, {v, r, a}, 3);
  endtask
  always @(samp) begin
    obb_note_t e;
    e = q.pop_front();
    case (e.k)
      0: cmp_decode(e.v[6:0], {osel, rom_n, str_n, rom_oe_n, m1o, m3o, ores});
      1: cmp_buffer(e.v[1:0], {dir, en_n});
      2: cmp_latch(e.v, {ovld, orw, oaddr});
      3: cmp_phase(e.v[0], dph);
      default: cmp_hold(e.v[0], dir);
    endcase
  end
  // Direction may only move while the drivers were off
  // Sampled away from the launching edge so outputs have settled
  always @(negedge clock_i) begin
    if (nrst && cyc > 12 && dir !== pd) cmp_drivers(2'h3, {pe, en_n});
    if (nrst && cyc > 12) cmp_forward({tmc_p, ph_p, nvmc_p}, {btmc, oph, onvm});
    pd <= dir;
    pe <= en_n;
    tmc_p <= tmc;
    ph_p <= ph_n;
    nvmc_p <= nvmc;
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    static logic [15:0] edges[10] = '{16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h7FFF,
      16'h8000, 16'h3FFB, 16'h3FFC, 16'hFFFF, 16'h1FFE};
    void'($urandom(32'h55f80fc2));
    repeat (10) @(posedge clock_i);
    nrst <= 1;
    nvm_sel <= 1;
    foreach (edges[i]) dec(edges[i]);
    repeat (40) dec(16'($urandom));
    $display("Decode test done");
    bus(16'h3000, 0, 0, 1, 2'b10);
    bus(16'h3000, 1, 0, 1, 2'b00);
    bus(16'h3000, 0, 0, 1, 2'b10);
    bus(16'h1000, 1, 1, 1, 2'b11);
    bus(16'h8000, 1, 0, 1, 2'b10);
    bus(16'h7FFF, 1, 0, 0, 2'b01);
    bus(16'h2000, 0, 0, 0, 2'b11);
    $display("Buffer test done");
    repeat (4) latch(16'($urandom), 1'($urandom), 1'($urandom));
    $display("Latch test done");
    finish_test();
  end
endmodule
`default_nettype wire
